// file: pwm_core.sv
// four channel pwm core: prescaler, two linear dividers, channels,
// channel enable and end-of-period flags with a masked interrupt.
// assumes one clock clk_sys, sync active-low reset, and control
// strobes that are one-cycle pulses from logic on the same clock.
`include "pwm_regs.svh"
`default_nettype none

// Functional notes
// (R1) modulo counter gives master clock divided by 1 through 1024
// (R2) two linear dividers, ratio 1 down to 1/255, make clocks a and b
// (R3) each divider divides its selected prescaled clock by its factor
// (R4) reset clears both factors and prescale selects, stopping a and b
// (R5) reset or gated master clock stops all prescaled clocks but undivided
// (R6) four channels, each with selector, counter and comparator
// (R7) each channel counter is 16 bits, direction set by alignment
// (R8) channel clock select resets to zero
// (R9) polarity gives the level at period start, default low
// (R10) alignment selects left or center, default left
// (R11) center mode counts up to period then down to zero
// (R12) left mode counts up to period then returns to zero
// (R13) duty equal period or zero pins output per polarity
// (R14) polarity is set while disabled, shows at once, ignored when enabled
// (R15) software changes polarity and alignment only while disabled
// (R16) period and duty directly writable only while channel disabled
// (R17) channels enabled in one write start in the same cycle
// (R18) update value is held until period end, then applied
// (R19) update target bit picks period or duty as destination
// (R20) software never programs a period below the duty value
// (R21) period end sets channel flag, interrupt raised if masked in
// (R22) interrupt holds until status read, which clears all flags
// (R23) ones to irq enable set mask bits, to irq disable clear them
// (R24) factor zero stops divided clock, one passes, two up divides
// (R25) ones to disable turn channels off; status shows enabled set
// (R26) all logic on master clock, divided clocks are enable pulses
// (R27) output leaves its start level once counter reaches duty
module pwm_core #(
  parameter int CHANNELS = `PWM_CHANNELS,
  parameter int W = `PWM_CNT_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic master_clock_on,
  input wire logic mode_write,
  input wire pwm_pkg::clock_sel_t prescale_select_a,
  input wire pwm_pkg::clock_sel_t prescale_select_b,
  input wire logic [7:0] divide_factor_a,
  input wire logic [7:0] divide_factor_b,
  input wire logic [CHANNELS-1:0] cfg_write,
  input wire pwm_pkg::clock_sel_t channel_clock_select,
  input wire logic channel_polarity,
  input wire pwm_pkg::align_t channel_alignment,
  input wire pwm_pkg::update_target_t update_target_select,
  input wire logic [CHANNELS-1:0] period_write,
  input wire logic [CHANNELS-1:0] duty_write,
  input wire logic [CHANNELS-1:0] update_write,
  input wire logic [W-1:0] value_data,
  input wire logic [CHANNELS-1:0] channel_enable_set,
  input wire logic [CHANNELS-1:0] channel_disable_set,
  input wire logic [CHANNELS-1:0] irq_enable_set,
  input wire logic [CHANNELS-1:0] irq_disable_set,
  input wire logic irq_status_read,
  output logic [CHANNELS-1:0] channel_enabled,
  output logic [CHANNELS-1:0] irq_mask,
  output logic [CHANNELS-1:0] irq_flags,
  output logic irq,
  output logic [CHANNELS-1:0] waveform_output,
  output logic divided_clock_a,
  output logic divided_clock_b
);
  import pwm_pkg::*;

  localparam int TAPS = `PWM_PRESCALE_TAPS;
  localparam int PB = `PWM_PRESCALE_BITS;
  localparam int DW = `PWM_DIV_WIDTH;
  localparam logic [PB-1:0] PRE_ONE = PB'(1);
  localparam logic [DW-1:0] DIV_ONE = DW'(1);
  localparam logic [DW-1:0] DIV_ZERO = '0;

  // pick a prescaled tick by select code; reserved codes give none
  function automatic logic pick_tap(input logic [TAPS-1:0] taps, input clock_sel_t sel);
    pick_tap = (sel < clock_sel_t'(TAPS)) ? taps[sel] : 1'b0;
  endfunction

  // channel source: prescaled tick, divided clock a or b
  function automatic logic pick_source(input logic [TAPS-1:0] taps, input logic a,
                                       input logic b, input clock_sel_t sel);
    if (sel == `PWM_SEL_CLOCK_A) pick_source = a;
    else if (sel == `PWM_SEL_CLOCK_B) pick_source = b;
    else pick_source = pick_tap(taps, sel);
  endfunction

  // ---- mode register ----
  clock_sel_t pre_sel_reg [2];
  logic [DW-1:0] factor_reg [2];

  // mode fields reset to zero so both divided clocks start stopped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_sel_reg[0] <= `PWM_RST_PRESCALE; // (R4)
      pre_sel_reg[1] <= `PWM_RST_PRESCALE; // (R4)
      factor_reg[0] <= `PWM_RST_DIVIDE; // (R4)
      factor_reg[1] <= `PWM_RST_DIVIDE; // (R4)
    end else if (mode_write) begin
      pre_sel_reg[0] <= prescale_select_a;
      pre_sel_reg[1] <= prescale_select_b;
      factor_reg[0] <= divide_factor_a;
      factor_reg[1] <= divide_factor_b;
    end
  end

  // ---- modulo n prescaler ----
  logic [PB-1:0] pre_cnt_reg;
  logic [TAPS-1:0] taps;

  // free counter halts while the master clock is gated off,
  // so every divided rate resumes where it left off
  always_ff @(posedge clk_sys) begin
    if (!rst_n) pre_cnt_reg <= '0;
    else if (master_clock_on) pre_cnt_reg <= pre_cnt_reg + PRE_ONE; // (R1)
  end

  // tap 0 is the undivided rate; tap i pulses once per 2**i cycles
  assign taps[0] = master_clock_on;
  genvar gi;
  generate
    for (gi = 1; gi < TAPS; gi++) begin : g_tap
      assign taps[gi] = rst_n & master_clock_on & (&pre_cnt_reg[gi-1:0]); // (R1) (R5)
    end
  endgenerate

  // ---- linear dividers a and b ----
  logic [1:0] div_tick;
  logic [1:0] div_src;

  // pulses are one-cycle enables, not clocks, so no second domain
  generate
    for (gi = 0; gi < 2; gi++) begin : g_div
      logic [DW-1:0] cnt_reg;
      logic [DW-1:0] cnt_inc;
      logic hit;
      assign div_src[gi] = pick_tap(taps, pre_sel_reg[gi]); // (R3)
      assign cnt_inc = cnt_reg + DIV_ONE;
      assign hit = (factor_reg[gi] != DIV_ZERO) && (cnt_inc >= factor_reg[gi]); // (R24)
      assign div_tick[gi] = div_src[gi] & hit; // (R2) (R26)
      // count source ticks; factor zero parks the counter
      always_ff @(posedge clk_sys) begin
        if (!rst_n || factor_reg[gi] == DIV_ZERO) cnt_reg <= DIV_ZERO;
        else if (div_src[gi]) cnt_reg <= hit ? DIV_ZERO : cnt_inc; // (R3)
      end
    end
  endgenerate

  assign divided_clock_a = div_tick[0];
  assign divided_clock_b = div_tick[1];

  // ---- channels ----
  logic [CHANNELS-1:0] step;
  logic [CHANNELS-1:0] period_end;
  clock_sel_t ch_sel [CHANNELS];

  // all channels share enable strobes, so one write starts them together
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      assign step[gi] = pick_source(taps, div_tick[0], div_tick[1], ch_sel[gi]); // (R6) (R26)
      pwm_channel #(.W(W)) u_pwm_channel (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .step(step[gi]),
        .cfg_write(cfg_write[gi]),
        .clock_select_in(channel_clock_select),
        .polarity_in(channel_polarity),
        .alignment_in(channel_alignment),
        .update_target_in(update_target_select),
        .period_write(period_write[gi]),
        .duty_write(duty_write[gi]),
        .update_write(update_write[gi]),
        .value_data(value_data),
        .enable_set(channel_enable_set[gi]), // (R17)
        .disable_set(channel_disable_set[gi]),
        .clock_select(ch_sel[gi]),
        .enabled(channel_enabled[gi]),
        .waveform(waveform_output[gi]),
        .period_end(period_end[gi])
      );
    end
  endgenerate

  // ---- flags, mask and interrupt ----
  logic [CHANNELS-1:0] flags_reg, flags_next;
  logic [CHANNELS-1:0] mask_reg, mask_next;
  logic irq_reg;

  // a read clears every flag, but a period end in the same cycle
  // sets again so that event is not lost
  assign flags_next = period_end | (flags_reg & {CHANNELS{~irq_status_read}}); // (R21) (R22)
  // disable wins if both strobes name the same channel
  assign mask_next = (mask_reg | irq_enable_set) & ~irq_disable_set; // (R23)

  // registered line tracks the registered flags and mask exactly
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      mask_reg <= mask_next;
      irq_reg <= |(flags_next & mask_next); // (R21)
    end
  end

  assign irq_flags = flags_reg;
  assign irq_mask = mask_reg;
  assign irq = irq_reg;

  // ---- checks ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // counter of cycles since the slowest tap fired
  logic [PB:0] gap_cnt;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || taps[TAPS-1]) gap_cnt <= '0;
    else if (master_clock_on && gap_cnt != '1) gap_cnt <= gap_cnt + 11'h001;
  end

  // the slowest tap must fire exactly once per 1024 running cycles
  property p_slow_tap;
    taps[TAPS-1] |-> gap_cnt == 11'h3FF;
  endproperty
  a_slow_tap: assert property (p_slow_tap) else $error("divide by 1024 spacing wrong"); // (R1)

  property p_gated;
    !master_clock_on |-> taps[TAPS-1:1] == '0;
  endproperty
  a_gated: assert property (p_gated) else $error("prescaled tick while gated"); // (R5)

  // no divided clock may tick while the master clock is gated
  property p_div_gated;
    !master_clock_on |-> !divided_clock_a && !divided_clock_b;
  endproperty
  a_div_gated: assert property (p_div_gated) else $error("divided clock while gated"); // (R5)

  property p_factor_zero;
    factor_reg[0] == DIV_ZERO |-> !divided_clock_a;
  endproperty
  a_factor_zero: assert property (p_factor_zero) else $error("clock a runs at factor zero"); // (R24)

  property p_factor_one;
    factor_reg[1] == DIV_ONE && div_src[1] |-> divided_clock_b;
  endproperty
  a_factor_one: assert property (p_factor_one) else $error("factor one did not pass clock"); // (R24)

  property p_factor_three;
    factor_reg[1] == 8'h03 && divided_clock_b && pre_sel_reg[1] == 4'h0 && master_clock_on
      ##1 master_clock_on && $stable(factor_reg[1]) && $stable(pre_sel_reg[1])
      |-> !divided_clock_b ##1 (master_clock_on && $stable(factor_reg[1])) |-> !divided_clock_b;
  endproperty
  a_factor_three: assert property (p_factor_three) else $error("divide by three wrong"); // (R3)

  property p_mode_reset;
    !rst_n ##1 rst_n |-> factor_reg[0] == DIV_ZERO && factor_reg[1] == DIV_ZERO
      && pre_sel_reg[0] == 4'h0 && pre_sel_reg[1] == 4'h0;
  endproperty
  a_mode_reset: assert property (disable iff (1'b0) p_mode_reset) else $error("mode not reset"); // (R4)

  property p_flag_set;
    period_end[0] |=> irq_flags[0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("period end lost"); // (R21)

  property p_read_clear;
    irq_status_read && period_end == '0 |=> irq_flags == '0 && !irq;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear"); // (R22)

  property p_irq_hold;
    irq && !irq_status_read && irq_disable_set == '0 |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early"); // (R22)

  // channel 3 is the one whose mask the bench toggles
  property p_mask_set;
    irq_enable_set[3] && !irq_disable_set[3] ##1 irq_disable_set[3] == 1'b0 |-> irq_mask[3];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask bit not set"); // (R23)

  // every channel named in one enable strobe and not in the same-cycle disable starts on the same edge
  property p_sync_start;
    (channel_enable_set & ~channel_disable_set) != '0
      |=> (channel_enabled & $past(channel_enable_set & ~channel_disable_set))
        == $past(channel_enable_set & ~channel_disable_set);
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("channels not started together"); // (R17)

  // a disable strobe always wins, even against a same-cycle enable
  property p_disable;
    channel_disable_set != '0 |=> (channel_enabled & $past(channel_disable_set)) == '0;
  endproperty
  a_disable: assert property (p_disable) else $error("channel still on after disable"); // (R25)

  c_irq_raised: cover property (irq && irq_mask[0]);
  c_div_b_run: cover property (divided_clock_b && factor_reg[1] > 8'h01);
  c_read_race: cover property (irq_status_read && period_end != '0);
endmodule

`default_nettype wire

// file: pwm_regs.svh
// reset values, field widths and select codes of the pwm core
// assumes inclusion by bare name from the pwm design files
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

`define PWM_CHANNELS 4
`define PWM_CNT_WIDTH 16
`define PWM_DIV_WIDTH 8
`define PWM_SEL_WIDTH 4
`define PWM_PRESCALE_TAPS 11
`define PWM_PRESCALE_BITS 10
`define PWM_SEL_CLOCK_A 4'hB
`define PWM_SEL_CLOCK_B 4'hC
`define PWM_RST_DIVIDE 8'h00
`define PWM_RST_PRESCALE 4'h0
`define PWM_RST_CLOCK_SEL 4'h0
`define PWM_RST_COUNT 16'h0000
`define PWM_RST_PERIOD 16'h0000
`define PWM_RST_DUTY 16'h0000

`endif

// file: pwm_pkg.sv
// types shared by the pwm core and its channels
// assumes pwm_regs.svh is on the include path
`default_nettype none

package pwm_pkg;
  // counter alignment of one channel
  typedef enum logic {ALIGN_LEFT, ALIGN_CENTER} align_t;
  // which value a held update replaces
  typedef enum logic {TARGET_DUTY, TARGET_PERIOD} update_target_t;
  // clock source code of a channel or divider
  typedef logic [3:0] clock_sel_t;
endpackage

`default_nettype wire

// file: pwm_channel.sv
// one pwm channel: config, counter, double buffer, comparator
// assumes single clock clk_sys, sync reset, step pulse from the core
`include "pwm_regs.svh"
`default_nettype none

module pwm_channel #(
  parameter int W = `PWM_CNT_WIDTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic step,
  input wire logic cfg_write,
  input wire pwm_pkg::clock_sel_t clock_select_in,
  input wire logic polarity_in,
  input wire pwm_pkg::align_t alignment_in,
  input wire pwm_pkg::update_target_t update_target_in,
  input wire logic period_write,
  input wire logic duty_write,
  input wire logic update_write,
  input wire logic [W-1:0] value_data,
  input wire logic enable_set,
  input wire logic disable_set,
  output pwm_pkg::clock_sel_t clock_select,
  output logic enabled,
  output logic waveform,
  output logic period_end
);
  import pwm_pkg::*;

  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = '0;

  clock_sel_t sel_reg;
  logic pol_reg, en_reg, down_reg, down_next, pend_reg, end_now, wave_reg, wave_next, end_reg;
  align_t align_reg;
  update_target_t tgt_reg;
  logic [W-1:0] cnt_reg, cnt_next, period_reg, duty_reg, upd_reg;

  // counter step; up to period then wrap or turn down
  always_comb begin
    cnt_next = cnt_reg;
    down_next = down_reg;
    end_now = 1'b0;
    if (enable_set && !en_reg) begin
      cnt_next = ZERO; // (R17)
      down_next = 1'b0;
    end else if (en_reg && step) begin
      if (align_reg == ALIGN_CENTER && down_reg) begin
        cnt_next = cnt_reg - ONE; // (R11)
        if (cnt_reg <= ONE) begin
          cnt_next = ZERO;
          down_next = 1'b0;
          end_now = 1'b1;
        end
      end else if (cnt_reg >= period_reg) begin
        if (align_reg == ALIGN_LEFT || period_reg == ZERO) begin
          cnt_next = ZERO; // (R12)
          end_now = 1'b1;
        end else begin
          cnt_next = cnt_reg - ONE; // (R11)
          down_next = 1'b1;
        end
      end else begin
        cnt_next = cnt_reg + ONE; // (R7)
      end
    end
  end

  // fixed levels first, then the duty threshold flips the level
  always_comb begin
    if (!en_reg) wave_next = pol_reg; // (R14)
    else if (duty_reg == period_reg) wave_next = pol_reg; // (R13)
    else if (duty_reg == ZERO) wave_next = ~pol_reg; // (R13)
    else wave_next = (cnt_reg < duty_reg) ? pol_reg : ~pol_reg; // (R27) (R9)
  end

  // config is frozen while running so the waveform cannot glitch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_reg <= `PWM_RST_CLOCK_SEL; // (R8)
      pol_reg <= 1'b0; // (R9)
      align_reg <= ALIGN_LEFT; // (R10)
      tgt_reg <= TARGET_DUTY;
    end else if (cfg_write && !en_reg) begin
      sel_reg <= clock_select_in;
      pol_reg <= polarity_in; // (R14)
      align_reg <= alignment_in;
      tgt_reg <= update_target_in;
    end
  end

  // direct writes only while stopped; held update lands at period end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      period_reg <= `PWM_RST_PERIOD;
      duty_reg <= `PWM_RST_DUTY;
      upd_reg <= ZERO;
      pend_reg <= 1'b0;
    end else begin
      if (period_write && !en_reg) period_reg <= value_data; // (R16)
      else if (end_now && pend_reg && tgt_reg == TARGET_PERIOD) period_reg <= upd_reg; // (R19)
      if (duty_write && !en_reg) duty_reg <= value_data; // (R16)
      else if (end_now && pend_reg && tgt_reg == TARGET_DUTY) duty_reg <= upd_reg; // (R19)
      if (update_write) upd_reg <= value_data;
      pend_reg <= update_write | (pend_reg & ~end_now); // (R18)
    end
  end

  // enable, counter and output state; disable wins a tie
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en_reg <= 1'b0;
      cnt_reg <= `PWM_RST_COUNT;
      down_reg <= 1'b0;
      wave_reg <= 1'b0;
      end_reg <= 1'b0;
    end else begin
      en_reg <= ~disable_set & (en_reg | enable_set); // (R25)
      cnt_reg <= cnt_next;
      down_reg <= down_next;
      wave_reg <= wave_next;
      end_reg <= end_now;
    end
  end

  assign clock_select = sel_reg;
  assign enabled = en_reg;
  assign waveform = wave_reg;
  assign period_end = end_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_cfg_frozen;
    en_reg && cfg_write |=> $stable(pol_reg) && $stable(align_reg);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed while enabled"); // (R14)

  property p_left_wrap;
    en_reg && step && align_reg == ALIGN_LEFT && cnt_reg >= period_reg && !disable_set
      |=> cnt_reg == ZERO && period_end;
  endproperty
  a_left_wrap: assert property (p_left_wrap) else $error("left counter did not wrap"); // (R12)

  property p_held_update;
    end_now && pend_reg && tgt_reg == TARGET_DUTY |=> duty_reg == $past(upd_reg);
  endproperty
  a_held_update: assert property (p_held_update) else $error("held update not applied"); // (R18)

  c_center_end: cover property (align_reg == ALIGN_CENTER && end_now);
endmodule

`default_nettype wire

// file: pwm_load.sv
// load model on one waveform pin: measures period and high time in cycles
// assumes the pin is driven from clk_sys and changes only after its edges
`default_nettype none

module pwm_load (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wave,
  output logic [15:0] period_len,
  output logic [15:0] high_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_reg;
  logic [15:0] cnt_reg;

  // counts from the last rise; a pin held flat keeps its old figures
  always_ff @(posedge clk_sys) begin
    last_reg <= wave;
    cnt_reg <= cnt_reg + 16'h0001;
    if (!rst_n) begin
      period_len <= 16'h0000;
      high_len <= 16'h0000;
      cnt_reg <= 16'h0000;
    end else if (wave && !last_reg) begin
      period_len <= cnt_reg;
      cnt_reg <= 16'h0001;
    end else if (!wave && last_reg) begin
      high_len <= cnt_reg;
    end
  end
endmodule

`default_nettype wire

// file: tb_pwm_core.sv
// self-checking bench for pwm_core, one load model on each waveform pin
// assumes pwm_pkg, pwm_regs.svh, pwm_channel and pwm_core compile first
`include "pwm_regs.svh"
`default_nettype none

module tb_pwm_core;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, clk_on, mode_wr, st_rd, pol, irq, clk_a, clk_b;
  clock_sel_t pre_a, pre_b, ch_sel;
  logic [7:0] div_a, div_b;
  logic [3:0] cfg_wr, per_wr, dut_wr, upd_wr, en_set, dis_set, ie_set, id_set;
  logic [3:0] enabled, mask, flags, wave;
  align_t algn;
  update_target_t tgt;
  logic [15:0] val;
  logic [15:0] per_len [4];
  logic [15:0] hi_len [4];
  int fails = 0;
  int total_checks = 0;
  logic [31:0] da, db;
  logic [31:0] hc [4];

  pwm_core u_pwm_core (.clk_sys(clk_sys), .rst_n(rst_n), .master_clock_on(clk_on),
    .mode_write(mode_wr), .prescale_select_a(pre_a), .prescale_select_b(pre_b),
    .divide_factor_a(div_a), .divide_factor_b(div_b), .cfg_write(cfg_wr),
    .channel_clock_select(ch_sel), .channel_polarity(pol), .channel_alignment(algn),
    .update_target_select(tgt), .period_write(per_wr), .duty_write(dut_wr),
    .update_write(upd_wr), .value_data(val), .channel_enable_set(en_set),
    .channel_disable_set(dis_set), .irq_enable_set(ie_set), .irq_disable_set(id_set),
    .irq_status_read(st_rd), .channel_enabled(enabled), .irq_mask(mask),
    .irq_flags(flags), .irq(irq), .waveform_output(wave), .divided_clock_a(clk_a),
    .divided_clock_b(clk_b));

  // one load per pin
  for (genvar i = 0; i < 4; i++) begin : g_load
    pwm_load u_pwm_load (.clk_sys(clk_sys), .rst_n(rst_n), .wave(wave[i]),
      .period_len(per_len[i]), .high_len(hi_len[i]));
  end

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one-cycle strobe; kind picks the port, all strobes drop together
  task automatic strobe(input int k, input logic [3:0] m);
    @(posedge clk_sys);
    case (k)
      0: cfg_wr <= m;
      1: per_wr <= m;
      2: dut_wr <= m;
      3: upd_wr <= m;
      4: en_set <= m;
      5: dis_set <= m;
      6: ie_set <= m;
      7: id_set <= m;
      8: mode_wr <= 1'b1;
      default: st_rd <= 1'b1;
    endcase
    @(posedge clk_sys);
    {cfg_wr, per_wr, dut_wr, upd_wr, en_set, dis_set, ie_set, id_set} <= 32'h0;
    {mode_wr, st_rd} <= 2'h0;
  endtask

  // kind 1 period, 2 duty, 3 update
  task automatic wr(input int k, input int ch, input logic [15:0] v);
    @(posedge clk_sys);
    val <= v;
    strobe(k, 4'h1 << ch);
  endtask

  task automatic cfg(input int ch, input clock_sel_t s, input logic p, input align_t a,
                     input update_target_t t);
    @(posedge clk_sys);
    ch_sel <= s;
    pol <= p;
    algn <= a;
    tgt <= t;
    strobe(0, 4'h1 << ch);
  endtask

  task automatic mode(input int a, input int b, input logic [7:0] fa, input logic [7:0] fb);
    @(posedge clk_sys);
    pre_a <= clock_sel_t'(a);
    pre_b <= clock_sel_t'(b);
    div_a <= fa;
    div_b <= fb;
    strobe(8, 4'h0);
  endtask

  // pin highs and divider pulses over n cycles, sampled after the edge settles
  task automatic watch(input int n);
    da = '0;
    db = '0;
    hc = '{default: '0};
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      da += {31'h0, clk_a};
      db += {31'h0, clk_b};
      for (int i = 0; i < 4; i++) hc[i] += {31'h0, wave[i]};
    end
  endtask

  // watchdog: the full sequence needs about 25k cycles
  initial begin
    cyc(60000);
    fails++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    clk_on = 1'b1;
    {mode_wr, st_rd, pol, pre_a, pre_b, ch_sel, div_a, div_b, val} = '0;
    {cfg_wr, per_wr, dut_wr, upd_wr, en_set, dis_set, ie_set, id_set} = 32'h0;
    algn = ALIGN_LEFT;
    tgt = TARGET_DUTY;
    cyc(4);
    rst_n <= 1'b1;
    watch(20);
    chk({enabled, mask, flags, irq}, 32'h0);
    chk(wave, 4'h0);
    chk(da + db, 0);
    // every prescaler tap, divider a passes it, divider b halves it
    for (int t = 0; t < 11; t++) begin
      mode(t, t, 8'h01, 8'h02);
      cyc((4 << t) + 2);
      watch(8 << t);
      chk(da, 8);
      chk(db, 4);
    end
    mode(0, 0, 8'h00, 8'h03);
    cyc(8);
    watch(30);
    chk(da, 0);
    chk(db, 10);
    mode(1, 0, 8'h01, 8'h01);
    @(posedge clk_sys);
    clk_on <= 1'b0;
    watch(20);
    chk(da, 0);
    chk(db, 0);
    cyc(1);
    clk_on <= 1'b1;
    // ch0 untouched config, ch1 inverted; started in one write
    wr(1, 0, 16'h0009);
    wr(2, 0, 16'h0003);
    cfg(1, 4'h0, 1'b1, ALIGN_LEFT, TARGET_PERIOD);
    wr(1, 1, 16'h0009);
    wr(2, 1, 16'h0003);
    cyc(2);
    #1;
    chk(wave, 4'h2);
    strobe(4, 4'h3);
    watch(40);
    chk(hc[0] + hc[1], 40);
    chk(per_len[0], 10);
    chk(hi_len[0], 7);
    chk(hi_len[1], 3);
    chk(enabled, 4'h3);
    // direct writes and polarity while running must not land
    wr(2, 0, 16'h0001);
    cfg(0, 4'h0, 1'b1, ALIGN_LEFT, TARGET_DUTY);
    watch(30);
    chk(hi_len[0], 7);
    chk(per_len[0], 10);
    wr(3, 0, 16'h0005);
    wr(3, 1, 16'h000D);
    watch(40);
    chk(hi_len[0], 5);
    chk(per_len[1], 14);
    chk(hi_len[1], 3);
    // fixed-level corners on ch2: bit0 polarity, bit1 duty equal to period
    for (int k = 0; k < 4; k++) begin
      strobe(5, 4'h4);
      cfg(2, 4'h0, k[0], ALIGN_LEFT, TARGET_DUTY);
      wr(1, 2, 16'h0005);
      wr(2, 2, k[1] ? 16'h0005 : 16'h0000);
      strobe(4, 4'h4);
      cyc(3);
      watch(24);
      chk(hc[2], (k[0] ^ k[1]) ? 0 : 24);
    end
    // ch2 on divided clock a, ch3 on divided clock b, both every second cycle
    mode(0, 0, 8'h02, 8'h02);
    strobe(5, 4'h4);
    cfg(2, `PWM_SEL_CLOCK_A, 1'b0, ALIGN_LEFT, TARGET_DUTY);
    wr(1, 2, 16'h0004);
    wr(2, 2, 16'h0002);
    strobe(4, 4'h4);
    watch(50);
    chk(per_len[2], 10);
    chk(hi_len[2], 6);
    // ch3 center aligned on clock b with its interrupt unmasked
    cfg(3, `PWM_SEL_CLOCK_B, 1'b0, ALIGN_CENTER, TARGET_DUTY);
    wr(1, 3, 16'h0006);
    wr(2, 3, 16'h0002);
    strobe(6, 4'h8);
    strobe(4, 4'h8);
    watch(50);
    chk(per_len[3], 24);
    chk(hi_len[3], 18);
    chk({mask, flags, irq}, {4'h8, 4'hF, 1'b1});
    strobe(7, 4'h8);
    strobe(6, 4'h0);
    cyc(2);
    #1;
    chk({mask, irq}, {4'h0, 1'b0});
    strobe(5, 4'hF);
    strobe(6, 4'h8);
    cyc(4);
    #1;
    chk({enabled, irq}, {4'h0, 1'b1});
    strobe(9, 4'h0);
    cyc(2);
    #1;
    chk({flags, irq}, {4'h0, 1'b0});
    stop_test();
  end
endmodule

`default_nettype wire
